//--- logic/fpwm_regs.svh
/*
 * Constants of the fan PWM duty controller: register field positions,
 * reset values, duty scale and timing counts.
 * Assumes a 250 MHz system clock and millivolt-coded voltage samples.
 */
`ifndef FPWM_REGS_SVH
`define FPWM_REGS_SVH

// Clock and timing figures, each in its own unit
`define FPWM_CLK_HZ 250000000
`define FPWM_PWM_HZ 30
`define FPWM_KICK_MS 1000
`define FPWM_KICK_CYCLES ((`FPWM_CLK_HZ / 1000) * `FPWM_KICK_MS)

// Duty scale: one unit is 1/150 of the period, so 100% is 150
`define FPWM_DUTY_UNITS 150
`define FPWM_DUTY_MIN 8'h2D
`define FPWM_DUTY_MAX 8'h96
`define FPWM_DUTY_OPEN 8'h3B
`define FPWM_DUTY_STEP 8'h07
`define FPWM_SLOT_CYCLES (`FPWM_CLK_HZ / (`FPWM_PWM_HZ * `FPWM_DUTY_UNITS))

// Voltage input range in millivolts and its linear slope (105/980)
`define FPWM_VIN_LO_MV 12'h654
`define FPWM_VIN_HI_MV 12'hA28
`define FPWM_VIN_NUM 12'h003
`define FPWM_VIN_DEN 12'h01C

// Configuration word
`define FPWM_CFG_PD_BIT 0
`define FPWM_CFG_SRC_BIT 5
`define FPWM_CFG_MASK 8'h21
`define FPWM_CFG_RST 8'h00

// Status word
`define FPWM_STAT_KICK_BIT 1
`define FPWM_STAT_ALERT_BIT 2
`define FPWM_STAT_OT_BIT 5

// Duty level register
`define FPWM_LEVEL_RST 4'h2

`endif

//--- logic/fpwm_pkg.sv
/*
 * Types shared by the fan PWM duty controller files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fpwm_pkg;

    typedef enum logic [1:0] {FPWM_OFF, FPWM_KICK, FPWM_RUN} fpwm_state_t;

    typedef logic [7:0] fpwm_duty_t;

    typedef struct packed {
        logic cfg_wr;
        logic level_wr;
        logic [7:0] wdata;
    } fpwm_reg_wr_t;

endpackage : fpwm_pkg

//--- logic/fpwm_slot_pwm.sv
/*
 * Fixed-period PWM core: a slot divider and a slot counter split each
 * period into DUTY_UNITS slots; the output is high while the slot index
 * is below the duty latched at the period start.
 * Assumes duty_in is on clk_sys and run drops to stop the output.
 */
`timescale 1ns/10ps
`include "fpwm_regs.svh"
module fpwm_slot_pwm
    import fpwm_pkg::*;
#(
    parameter int SLOT_CYCLES = `FPWM_SLOT_CYCLES,
    parameter int DUTY_UNITS = `FPWM_DUTY_UNITS
)(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic run,
    input wire fpwm_duty_t duty_in,
    output logic period_start,
    output logic pwm_q
);
    localparam int DW = $clog2(SLOT_CYCLES);
    localparam int SW = 8;

    logic [DW-1:0] div_q;
    logic [SW-1:0] slot_q;
    logic slot_en;
    fpwm_duty_t duty_lat_q;
    fpwm_duty_t duty_now;

    // One-cycle enable per slot keeps everything on the single clock
    assign slot_en = (div_q == DW'(SLOT_CYCLES - 1));
    assign period_start = run && (div_q == '0) && (slot_q == '0);
    assign duty_now = period_start ? duty_in : duty_lat_q;

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            div_q <= '0;
        else if (!run || slot_en)
            div_q <= '0;
        else
            div_q <= div_q + 1'b1;
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            slot_q <= '0;
        else if (!run)
            slot_q <= '0;
        else if (slot_en)
            slot_q <= (slot_q == SW'(DUTY_UNITS - 1)) ? '0 : slot_q + 1'b1;
    end

    // Duty taken only at the period start, so a change never cuts a pulse
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            duty_lat_q <= '0;
        else if (period_start)
            duty_lat_q <= duty_in;
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            pwm_q <= 1'b0;
        else
            pwm_q <= run && (slot_q < duty_now);
    end

    a_slot_bound: assert property (@(posedge clk_sys) disable iff (sys_rst)
        slot_q < SW'(DUTY_UNITS))
        else $error("slot index left the period");

    a_latch_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !period_start |=> $stable(duty_lat_q))
        else $error("duty threshold changed inside a period");

    a_full_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (run && duty_now == `FPWM_DUTY_MAX) [*2] |-> pwm_q)
        else $error("full duty output not continuously high");

endmodule : fpwm_slot_pwm

//--- logic/fpwm_duty_control.sv
/*
 * Fan PWM duty controller: configuration, duty level and status words,
 * one-second full-on start, voltage-to-duty mapping, over-temperature
 * flag and open-drain alert, and the fixed-period PWM drive output.
 * Assumes temp_voltage_in is a millivolt code from an on-chip converter
 * on clk_sys; temp_open_in and alert_in come from pins. The serial
 * interface sits outside and drives the register write port.
 */
// Overview of operation
// - Fixed-frequency pulse train, only high time varies
// - Duty always kept between 30% and 100%
// - High output means fan on; 100% stays high
// - Full duty for one second after start
// - After start, source select bit picks duty
// - Source select resets to voltage input
// - Open voltage input gives 39.33% duty
// - 1.62 V to 2.6 V maps onto 30%-100%
// - Below range, duty holds at 30%
// - Above 2.6 V sets flag, alert driven low
// - Source selection may change at any time
// - Level code n gives 30% plus n*70/15%
// - Output stops only on shutdown bit
// - Duty below 100% with input not above 2.6 V clears flag and alert
`timescale 1ns/10ps
`include "fpwm_regs.svh"
module fpwm_duty_control
    import fpwm_pkg::*;
#(
    parameter int KICK_CYCLES = `FPWM_KICK_CYCLES,
    parameter int SLOT_CYCLES = `FPWM_SLOT_CYCLES,
    parameter bit OT_ALERT_EN = 1'b1
)(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire fpwm_reg_wr_t reg_wr,
    output logic [7:0] cfg_rdata_q,
    output logic [3:0] level_rdata_q,
    output logic [7:0] status_rdata_q,
    input wire logic [11:0] temp_voltage_in,
    input wire logic temp_open_in,
    input wire logic alert_in,
    output logic alert_o,
    output logic alert_oe,
    output logic pwm_drive_out
);
    localparam int KW = $clog2(KICK_CYCLES + 1);

    fpwm_state_t state_q;
    logic [KW-1:0] kick_cnt_q;
    logic [7:0] cfg_q;
    logic [3:0] level_q;
    logic [1:0] open_sync_q;
    logic [1:0] alert_sync_q;
    logic open_s;
    logic src_sel;
    logic power_down_select;
    logic release_ev;
    logic kick_done;
    logic run;
    logic period_start;
    logic ot_set;
    logic ot_clr;
    logic overtemp_q;
    logic [11:0] vin_span;
    logic [11:0] vin_scaled;
    fpwm_duty_t vin_duty_d;
    fpwm_duty_t vin_duty_q;
    fpwm_duty_t level_duty;
    fpwm_duty_t duty_raw;
    fpwm_duty_t duty_sel;

    // Pin inputs pass two flops before any logic looks at them
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            open_sync_q <= 2'h0;
            alert_sync_q <= 2'h0;
        end
        else
        begin
            open_sync_q <= {open_sync_q[0], temp_open_in};
            alert_sync_q <= {alert_sync_q[0], ~alert_in};
        end
    end

    assign open_s = open_sync_q[1];

    // Configuration keeps its value through shutdown
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            cfg_q <= `FPWM_CFG_RST;
        else if (reg_wr.cfg_wr)
            cfg_q <= reg_wr.wdata & `FPWM_CFG_MASK;
    end

    assign src_sel = cfg_q[`FPWM_CFG_SRC_BIT];
    assign power_down_select = cfg_q[`FPWM_CFG_PD_BIT];
    assign release_ev = (state_q == FPWM_OFF) && !power_down_select;
    assign kick_done = (kick_cnt_q == KW'(KICK_CYCLES - 1));
    assign run = (state_q != FPWM_OFF);

    // Duty level returns to its default when shutdown is released
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            level_q <= `FPWM_LEVEL_RST;
        else if (release_ev)
            level_q <= `FPWM_LEVEL_RST;
        else if (reg_wr.level_wr)
            level_q <= reg_wr.wdata[3:0];
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            state_q <= FPWM_KICK;
        else
        begin
            unique case (state_q)
                FPWM_OFF:
                    if (!power_down_select)
                        state_q <= FPWM_KICK;
                FPWM_KICK:
                    if (power_down_select)
                        state_q <= FPWM_OFF;
                    else if (kick_done)
                        state_q <= FPWM_RUN;
                FPWM_RUN:
                    if (power_down_select)
                        state_q <= FPWM_OFF;
                default:
                    state_q <= FPWM_OFF;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            kick_cnt_q <= '0;
        else if (state_q != FPWM_KICK)
            kick_cnt_q <= '0;
        else if (!kick_done)
            kick_cnt_q <= kick_cnt_q + 1'b1;
    end

    // Constant divisor, so synthesis folds it into a small multiplier
    always_comb
    begin
        vin_span = temp_voltage_in - `FPWM_VIN_LO_MV;
        vin_scaled = (vin_span * `FPWM_VIN_NUM) / `FPWM_VIN_DEN;
        if (open_s)
            vin_duty_d = `FPWM_DUTY_OPEN;
        else if (temp_voltage_in <= `FPWM_VIN_LO_MV)
            vin_duty_d = `FPWM_DUTY_MIN;
        else if (temp_voltage_in >= `FPWM_VIN_HI_MV)
            vin_duty_d = `FPWM_DUTY_MAX;
        else
            vin_duty_d = `FPWM_DUTY_MIN + vin_scaled[7:0];
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            vin_duty_q <= `FPWM_DUTY_OPEN;
        else
            vin_duty_q <= vin_duty_d;
    end

    assign level_duty = `FPWM_DUTY_MIN + `FPWM_DUTY_STEP * {4'h0, level_q};

    always_comb
    begin
        unique case (state_q)
            FPWM_OFF:
                duty_raw = `FPWM_DUTY_MIN;
            FPWM_KICK:
                duty_raw = `FPWM_DUTY_MAX;
            FPWM_RUN:
                duty_raw = src_sel ? level_duty : vin_duty_q;
            default:
                duty_raw = `FPWM_DUTY_MIN;
        endcase
        // Clamp guards against a bad level code ever leaving the window
        if (duty_raw < `FPWM_DUTY_MIN)
            duty_sel = `FPWM_DUTY_MIN;
        else if (duty_raw > `FPWM_DUTY_MAX)
            duty_sel = `FPWM_DUTY_MAX;
        else
            duty_sel = duty_raw;
    end

    fpwm_slot_pwm #(
        .SLOT_CYCLES(SLOT_CYCLES),
        .DUTY_UNITS(`FPWM_DUTY_UNITS)
    ) u_slot_pwm (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .run(run),
        .duty_in(duty_sel),
        .period_start(period_start),
        .pwm_q(pwm_drive_out)
    );

    // Flag follows the input even in level mode; set wins over clear
    assign ot_set = run && !open_s && (temp_voltage_in > `FPWM_VIN_HI_MV);
    assign ot_clr = (duty_sel < `FPWM_DUTY_MAX);

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            overtemp_q <= 1'b0;
        else if (ot_set)
            overtemp_q <= 1'b1;
        else if (!run || ot_clr)
            overtemp_q <= 1'b0;
    end

    assign alert_o = 1'b0;
    assign alert_oe = OT_ALERT_EN && overtemp_q;

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            status_rdata_q <= 8'h00;
        else
        begin
            status_rdata_q <= 8'h00;
            status_rdata_q[`FPWM_STAT_OT_BIT] <= overtemp_q;
            status_rdata_q[`FPWM_STAT_KICK_BIT] <= (state_q == FPWM_KICK);
            status_rdata_q[`FPWM_STAT_ALERT_BIT] <= alert_sync_q[1];
        end
    end

    assign cfg_rdata_q = cfg_q;
    assign level_rdata_q = level_q;

    sequence s_release;
        $fell(power_down_select) && (state_q == FPWM_OFF);
    endsequence

    sequence s_kick_end;
        (state_q == FPWM_KICK) && kick_done && !power_down_select;
    endsequence

    a_kick_full: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_q == FPWM_KICK) |-> (duty_sel == `FPWM_DUTY_MAX))
        else $error("start period not at full duty");

    a_release_kick: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_release |=> (state_q == FPWM_KICK) && (kick_cnt_q == '0))
        else $error("shutdown release did not restart the kick");

    a_kick_to_run: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_kick_end |=> (state_q == FPWM_RUN) ##0
        (duty_sel == (src_sel ? level_duty : vin_duty_q)))
        else $error("start period did not hand over to selected source");

    a_duty_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (duty_sel >= `FPWM_DUTY_MIN) && (duty_sel <= `FPWM_DUTY_MAX))
        else $error("duty outside 30 to 100 percent");

    a_src_default: assert property (@(posedge clk_sys)
        sys_rst |=> !src_sel)
        else $error("source select not cleared by reset");

    a_open_duty: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (open_s && (state_q == FPWM_RUN) && !src_sel) [*2] |-> (duty_sel == 8'h3B))
        else $error("open input not at default duty");

    a_floor_duty: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!open_s && (temp_voltage_in < 12'h654)) |=> (vin_duty_q == 8'h2D))
        else $error("low input went below minimum duty");

    a_level_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ((state_q == FPWM_RUN) && src_sel && (level_q == 4'hF)) |-> (duty_sel == 8'h96))
        else $error("top level code not full duty");

    a_ot_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ot_set |=> overtemp_q && status_rdata_q[`FPWM_STAT_OT_BIT] == $past(overtemp_q))
        else $error("over-temperature not flagged");

    a_ot_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (overtemp_q && !ot_set && ot_clr) |=> !overtemp_q ##0 !alert_oe)
        else $error("over-temperature not released");

    a_alert_drive: assert property (@(posedge clk_sys) disable iff (sys_rst)
        alert_oe == (OT_ALERT_EN && overtemp_q) && !alert_o)
        else $error("alert pin not following flag");

    a_shutdown_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_q == FPWM_OFF) [*2] |-> !pwm_drive_out)
        else $error("drive output active in shutdown");

    a_run_pulses: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (run && period_start) |=> pwm_drive_out)
        else $error("drive output stopped without shutdown");

endmodule : fpwm_duty_control

//--- testbench/fpwm_fan_model.sv
/*
 * Far side of the fan drive: low-side switch and thermistor network.
 * Assumes the bench sets the sensed millivolts and the open state.
 */
`timescale 1ns/10ps
module fpwm_fan_model (
    input wire logic clk_sys,
    input wire logic pwm_drive_out,
    input wire logic alert_o,
    input wire logic alert_oe,
    input wire logic [11:0] set_mv,
    input wire logic set_open,
    output logic [11:0] temp_voltage_in,
    output logic temp_open_in,
    output logic alert_in,
    output logic fan_on
);
    logic [11:0] float_q = 12'h000;

    // Floating input wanders, so a held value cannot pass
    always @(posedge clk_sys)
        float_q <= float_q + 12'h5A3;

    assign temp_voltage_in = set_open ? float_q : set_mv;
    assign temp_open_in = set_open;
    // Pull-up on the shared alert wire
    assign alert_in = alert_oe ? alert_o : 1'b1;
    // Switch conducts while drive is high
    assign fan_on = pwm_drive_out;
endmodule : fpwm_fan_model

//--- testbench/fan_pwm_duty_control_test.sv
/*
 * Self-checking bench of the fan PWM duty controller.
 * Assumes the fan model on the far side and short kick and slot counts.
 */
`timescale 1ns/10ps
`include "fpwm_regs.svh"
`define CHECK(got, exp, msg) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            n_errors++; \
            $display("unexpected at %0t: %s", $time, msg); \
        end \
    end
module fan_pwm_duty_control_test;
    import fpwm_pkg::*;
    localparam int KICK = 200;
    // Short slot keeps the run brief; frequency scales alike
    localparam int SLOT = 4;
    localparam int PER = SLOT * `FPWM_DUTY_UNITS;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    fpwm_reg_wr_t reg_wr = '0;
    logic [7:0] cfg_rdata_q, status_rdata_q;
    logic [3:0] level_rdata_q;
    logic [11:0] temp_voltage_in;
    logic [11:0] set_mv = 12'h3E8;
    logic set_open = 1'b0;
    logic temp_open_in, alert_in, alert_o, alert_oe, pwm_drive_out, fan_on;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;

    always #2 clk_sys = ~clk_sys;

    fpwm_duty_control #(.KICK_CYCLES(KICK), .SLOT_CYCLES(SLOT), .OT_ALERT_EN(1'b1)) u_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr(reg_wr),
        .cfg_rdata_q(cfg_rdata_q), .level_rdata_q(level_rdata_q),
        .status_rdata_q(status_rdata_q), .temp_voltage_in(temp_voltage_in),
        .temp_open_in(temp_open_in), .alert_in(alert_in), .alert_o(alert_o),
        .alert_oe(alert_oe), .pwm_drive_out(pwm_drive_out));

    fpwm_fan_model u_fan (
        .clk_sys(clk_sys), .pwm_drive_out(pwm_drive_out), .alert_o(alert_o),
        .alert_oe(alert_oe), .set_mv(set_mv), .set_open(set_open),
        .temp_voltage_in(temp_voltage_in), .temp_open_in(temp_open_in),
        .alert_in(alert_in), .fan_on(fan_on));

    task give_verdict;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 70000)
        begin
            n_errors++;
            give_verdict();
        end
    end

    task wr(input logic cfg, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= '{cfg_wr: cfg, level_wr: !cfg, wdata: d};
        @(posedge clk_sys);
        reg_wr <= '0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : wr

    // Any window of one period holds exactly one period's high time
    task measure(input logic [15:0] exp_hi, input string msg);
        logic [15:0] hi;
        logic [15:0] rises;
        logic p;
        hi = 16'h0000;
        rises = 16'h0000;
        repeat (2 * PER) @(posedge clk_sys);
        #1;
        p = fan_on;
        repeat (PER)
        begin
            @(posedge clk_sys);
            #1;
            hi += 16'(fan_on);
            if (fan_on && !p)
                rises++;
            p = fan_on;
        end
        `CHECK(hi, exp_hi, msg)
        `CHECK(rises, (exp_hi == 16'(PER)) ? 16'h0000 : 16'h0001, "pulse count")
    endtask : measure

    task kick_hold;
        int lows;
        lows = 0;
        repeat (KICK - 20)
        begin
            @(posedge clk_sys);
            #1;
            if (fan_on !== 1'b1)
                lows++;
        end
        `CHECK(lows, 0, "start kick not full on")
        `CHECK(status_rdata_q[`FPWM_STAT_KICK_BIT], 1'b1, "kick status")
    endtask : kick_hold

    task t_reset;
        #1;
        `CHECK(cfg_rdata_q, `FPWM_CFG_RST, "config reset")
        `CHECK(level_rdata_q, `FPWM_LEVEL_RST, "level reset")
        `CHECK(status_rdata_q, 8'h00, "status reset")
        kick_hold();
    endtask : t_reset

    task t_voltage;
        logic [11:0] mv [4];
        logic [7:0] units [4];
        mv = '{12'h3E8, 12'h654, 12'h83E, 12'hA28};
        units = '{8'h2D, 8'h2D, 8'h61, 8'h96};
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_sys);
            set_mv <= mv[i];
            measure(16'(units[i] * SLOT), "voltage duty");
        end
        `CHECK(status_rdata_q[`FPWM_STAT_OT_BIT], 1'b0, "flag at exactly top")
    endtask : t_voltage

    task t_open;
        @(posedge clk_sys);
        set_open <= 1'b1;
        measure(16'(`FPWM_DUTY_OPEN * SLOT), "open input duty");
        @(posedge clk_sys);
        set_open <= 1'b0;
    endtask : t_open

    task t_overtemp;
        @(posedge clk_sys);
        set_mv <= 12'hA8C;
        measure(16'(PER), "clamped at full");
        `CHECK(alert_oe, 1'b1, "alert not pulled")
        `CHECK(alert_in, 1'b0, "alert wire not low")
        `CHECK(status_rdata_q[`FPWM_STAT_OT_BIT], 1'b1, "flag not set")
        `CHECK(status_rdata_q[`FPWM_STAT_ALERT_BIT], 1'b1, "alert not seen")
        @(posedge clk_sys);
        set_mv <= 12'h7D0;
        repeat (6) @(posedge clk_sys);
        #1;
        `CHECK(alert_oe, 1'b0, "alert kept")
        `CHECK(status_rdata_q[`FPWM_STAT_OT_BIT], 1'b0, "flag kept")
    endtask : t_overtemp

    task t_level;
        wr(1'b1, 8'h20);
        `CHECK(cfg_rdata_q, 8'h20, "source select")
        for (int n = 0; n < 16; n++)
        begin
            wr(1'b0, 8'(n));
            `CHECK(level_rdata_q, 4'(n), "level readback")
            measure(16'((`FPWM_DUTY_MIN + `FPWM_DUTY_STEP * n) * SLOT), "level duty");
        end
        @(posedge clk_sys);
        set_mv <= 12'h3E8;
        wr(1'b1, 8'h00);
        measure(16'(`FPWM_DUTY_MIN * SLOT), "source change while running");
    endtask : t_level

    task t_shutdown;
        int hi;
        hi = 0;
        wr(1'b0, 8'h05);
        wr(1'b1, 8'hFF);
        `CHECK(cfg_rdata_q, `FPWM_CFG_MASK, "config mask")
        repeat (2 * PER)
        begin
            @(posedge clk_sys);
            #1;
            if (fan_on !== 1'b0)
                hi++;
        end
        `CHECK(hi, 0, "drive during shutdown")
        wr(1'b1, 8'h20);
        `CHECK(level_rdata_q, `FPWM_LEVEL_RST, "level after release")
        `CHECK(cfg_rdata_q, 8'h20, "config kept")
        kick_hold();
        measure(16'((`FPWM_DUTY_MIN + `FPWM_DUTY_STEP * 2) * SLOT), "duty after kick");
    endtask : t_shutdown

    initial
    begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_voltage();
        t_open();
        t_overtemp();
        t_level();
        t_shutdown();
        give_verdict();
    end
endmodule : fan_pwm_duty_control_test
